/* rtl/timer_pkg.sv */
// Package of the gated sixteen-bit timer: register map, field layouts, codes.
// Assumes a 32-bit APB master decoding the low eight address bits into this block.
package timer_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'h04;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'h08;
   localparam logic [7:0] ADDR_GATE_CONTROL = 8'h0C;
   localparam logic [7:0] ADDR_INT_STATUS = 8'h10;
   localparam logic [7:0] ADDR_INT_CLEAR = 8'h14;
   localparam logic [7:0] ADDR_INT_ENABLE = 8'h18;
   // Writable bit masks and reset values
   localparam logic [7:0] CONTROL_WMASK = 8'hF5;
   localparam logic [7:0] GATE_WMASK = 8'hC3;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] GATE_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam int STATUS_OVERFLOW = 0;
   // Clock source codes
   localparam logic [1:0] CS_INSTR = 2'h0;
   localparam logic [1:0] CS_SYS = 2'h1;
   localparam logic [1:0] CS_EXT = 2'h2;
   // Gate source codes
   localparam logic [1:0] GSS_PIN = 2'h0;
   localparam logic [1:0] GSS_AUX_A = 2'h1;
   localparam logic [1:0] GSS_AUX_B = 2'h2;
   localparam logic [1:0] GSS_WDT = 2'h3;
   // Instruction clock is the system clock divided by four
   localparam int INSTR_DIV = 4;

   typedef struct packed {
      logic [1:0] clock_source_select;
      logic [1:0] prescale_select;
      logic unused3;
      logic ext_clock_sync_bypass;
      logic unused1;
      logic counter_on;
   } ctrl_s;

   typedef struct packed {
      logic gate_enable;
      logic gate_polarity;
      logic [3:0] unused;
      logic [1:0] gate_source_select;
   } gate_s;
endpackage : timer_pkg

/* rtl/gated_sixteen_bit_timer.sv */
// Gated sixteen-bit timer with prescaler, gate, APB registers and overflow interrupt.
// Assumes one 100 MHz clock; pins arrive asynchronous, aux events come on clk.
//
// The implementer's own choices: the register offsets and register access over APB.
module gated_sixteen_bit_timer #(
   parameter int INSTR_DIV = timer_pkg::INSTR_DIV
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins, asynchronous
   input wire logic ext_clock_pin,
   input wire logic gate_pin,
   // Companion events on clk
   input wire logic aux_a_overflow,
   input wire logic aux_b_match,
   input wire logic wdt_timeout,
   input wire logic sleep,
   // Interrupt and wake
   output logic irq,
   output logic wake
);
   // Divider is two bits wide, so only the fixed divide by four fits
   if (INSTR_DIV != 4) begin : bad_div_check
      $error("instruction divider must be four");
   end

   timer_pkg::ctrl_s ctrl, next_ctrl;
   timer_pkg::gate_s gate_cfg, next_gate_cfg;
   logic [15:0] count, next_count;
   logic [2:0] pre_cnt, next_pre_cnt, pre_limit;
   logic [1:0] div_cnt, next_div_cnt;
   logic gate_ff, next_gate_ff, gate_raw, gate_ok;
   logic status, next_status, int_enable, next_int_enable;
   logic next_irq, next_wake;
   logic [31:0] next_prdata, rd_mux;
   logic next_pready, next_pslverr, mapped;
   logic access, done, wr, wr_low, wr_high, wr_count;
   logic ext_s1, ext_s2, ext_s3, ext_s4, gate_s1, gate_s2;
   logic instr_tick, src_tick, active_tick, count_en, pre_tick, ovf, ext_async;

   // Pin synchronisers; the extra stages only feed edge detectors
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         ext_s3 <= 1'b0;
         ext_s4 <= 1'b0;
         gate_s1 <= 1'b0;
         gate_s2 <= 1'b0;
      end else begin
         ext_s1 <= ext_clock_pin;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
         ext_s4 <= ext_s3;
         gate_s1 <= gate_pin;
         gate_s2 <= gate_s1;
      end
   end

   // APB decode
   always_comb begin
      access = psel & penable;
      done = access & pready;
      wr = done & pwrite;
      wr_low = wr & (paddr == timer_pkg::ADDR_COUNT_LOW);
      wr_high = wr & (paddr == timer_pkg::ADDR_COUNT_HIGH);
      wr_count = wr_low | wr_high;
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         timer_pkg::ADDR_CONTROL: rd_mux = 32'(ctrl & timer_pkg::CONTROL_WMASK);
         timer_pkg::ADDR_COUNT_LOW: rd_mux = 32'(count[7:0]);
         timer_pkg::ADDR_COUNT_HIGH: rd_mux = 32'(count[15:8]);
         timer_pkg::ADDR_GATE_CONTROL: rd_mux = 32'(gate_cfg & timer_pkg::GATE_WMASK);
         timer_pkg::ADDR_INT_STATUS: rd_mux = 32'(status);
         timer_pkg::ADDR_INT_CLEAR: rd_mux = 32'h0000_0000;
         timer_pkg::ADDR_INT_ENABLE: rd_mux = 32'(int_enable);
         default: mapped = 1'b0;
      endcase
      // One wait state so every bus output leaves a flop
      next_pready = access & ~pready;
      next_pslverr = access & ~pready & ~mapped;
      next_prdata = (access & ~pready) ? rd_mux : 32'h0000_0000;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
      end
   end

   // Timer datapath
   always_comb begin
      next_div_cnt = div_cnt + 2'h1;
      instr_tick = (div_cnt == 2'(INSTR_DIV - 1));
      // Bypass edge is one stage earlier, so switching skips or doubles
      ext_async = ext_s2 & ~ext_s3;
      // Clock source selection, reserved code never counts
      case (ctrl.clock_source_select)
         timer_pkg::CS_INSTR: src_tick = instr_tick;
         timer_pkg::CS_SYS: src_tick = 1'b1;
         // Bypass only matters for the external source
         timer_pkg::CS_EXT: src_tick = ctrl.ext_clock_sync_bypass ? ext_async : (ext_s3 & ~ext_s4);
         default: src_tick = 1'b0;
      endcase
      // Only the unsynchronized external path runs during sleep
      active_tick = src_tick & (~sleep | ((ctrl.clock_source_select == timer_pkg::CS_EXT)
         & ctrl.ext_clock_sync_bypass));
      // Pin and aux A gate sources
      // Aux B and watchdog gate sources
      case (gate_cfg.gate_source_select)
         timer_pkg::GSS_PIN: gate_raw = gate_s2;
         timer_pkg::GSS_AUX_A: gate_raw = aux_a_overflow;
         timer_pkg::GSS_AUX_B: gate_raw = aux_b_match;
         timer_pkg::GSS_WDT: gate_raw = wdt_timeout;
         default: gate_raw = 1'b0;
      endcase
      next_gate_ff = ctrl.counter_on & (gate_raw == gate_cfg.gate_polarity);
      gate_ok = ~gate_cfg.gate_enable | gate_ff;
      count_en = ctrl.counter_on & gate_ok & active_tick;
      case (ctrl.prescale_select)
         2'h0: pre_limit = 3'h0;
         2'h1: pre_limit = 3'h1;
         2'h2: pre_limit = 3'h3;
         default: pre_limit = 3'h7;
      endcase
      pre_tick = count_en & (pre_cnt == pre_limit);
      // Count write clears the hidden prescaler
      if (wr_count) begin
         next_pre_cnt = 3'h0;
      end else if (count_en) begin
         next_pre_cnt = pre_tick ? 3'h0 : pre_cnt + 3'h1;
      end else begin
         next_pre_cnt = pre_cnt;
      end
      // Wrap from all ones to zero
      ovf = pre_tick & ~wr_count & (count == timer_pkg::COUNT_MAX);
      if (wr_low) begin
         next_count = {count[15:8], pwdata[7:0]};
      end else if (wr_high) begin
         next_count = {pwdata[7:0], count[7:0]};
      end else if (pre_tick) begin
         next_count = count + 16'h0001;
      end else begin
         next_count = count;
      end
      next_ctrl = ctrl;
      next_gate_cfg = gate_cfg;
      next_int_enable = int_enable;
      if (wr & (paddr == timer_pkg::ADDR_CONTROL)) begin
         next_ctrl = timer_pkg::ctrl_s'(pwdata[7:0] & timer_pkg::CONTROL_WMASK);
      end
      if (wr & (paddr == timer_pkg::ADDR_GATE_CONTROL)) begin
         next_gate_cfg = timer_pkg::gate_s'(pwdata[7:0] & timer_pkg::GATE_WMASK);
      end
      if (wr & (paddr == timer_pkg::ADDR_INT_ENABLE)) begin
         next_int_enable = pwdata[timer_pkg::STATUS_OVERFLOW];
      end
      // Set beats clear in the same cycle
      next_status = status;
      if (wr & (paddr == timer_pkg::ADDR_INT_CLEAR) & pwdata[timer_pkg::STATUS_OVERFLOW]) begin
         next_status = 1'b0;
      end
      if (ovf) begin
         next_status = 1'b1;
      end
      next_irq = next_status & next_int_enable;
      // Overflow during sleep wakes the core when int_enable is set
      next_wake = ovf & sleep & int_enable;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= 2'h0;
         ctrl <= timer_pkg::ctrl_s'(timer_pkg::CONTROL_RESET);
         gate_cfg <= timer_pkg::gate_s'(timer_pkg::GATE_RESET);
         count <= timer_pkg::COUNT_RESET;
         pre_cnt <= 3'h0;
         gate_ff <= 1'b0;
         status <= 1'b0;
         int_enable <= 1'b0;
         irq <= 1'b0;
         wake <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         ctrl <= next_ctrl;
         gate_cfg <= next_gate_cfg;
         count <= next_count;
         pre_cnt <= next_pre_cnt;
         gate_ff <= next_gate_ff;
         status <= next_status;
         int_enable <= next_int_enable;
         irq <= next_irq;
         wake <= next_wake;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   ctrl_zero_bits_a: assert property (
      done && !pwrite && paddr == timer_pkg::ADDR_CONTROL |-> prdata[3] == 1'b0 && !prdata[1])
      else $error("unimplemented control bit read nonzero");
   off_holds_a: assert property (
      !ctrl.counter_on && !wr_count |=> $stable(count) && !gate_ff)
      else $error("count moved or gate flop set while off");
   gate_hold_a: assert property (
      gate_cfg.gate_enable && !gate_ff && !wr_count |=> $stable(count))
      else $error("count moved with gate inactive");
   gate_polarity_a: assert property (
      ctrl.counter_on |=> gate_ff == ($past(gate_raw) == $past(gate_cfg.gate_polarity)))
      else $error("gate flop ignores polarity");
   prescale_clear_a: assert property (
      wr_count |=> pre_cnt == 3'h0)
      else $error("prescaler not cleared by count write");
   rollover_flag_a: assert property (
      pre_tick && !wr_count && count == timer_pkg::COUNT_MAX |=> count == 16'h0000 && status)
      else $error("rollover did not wrap or flag");
   sys_clock_count_a: assert property (
      ctrl.counter_on && ctrl.clock_source_select == timer_pkg::CS_SYS && !sleep
      && ctrl.prescale_select == 2'h0 && !gate_cfg.gate_enable && !wr_count
      |=> count == $past(count) + 16'h0001)
      else $error("system clock did not count every cycle");
   div8_spacing_a: assert property (
      pre_tick && ctrl.prescale_select == 2'h3 && !wr_count
      && $stable(ctrl) |=> !pre_tick [*7])
      else $error("divide by eight ticked too early");
   sleep_stop_a: assert property (
      sleep && !(ctrl.clock_source_select == timer_pkg::CS_EXT && ctrl.ext_clock_sync_bypass)
      && !wr_count |=> $stable(count))
      else $error("count moved in sleep without bypass");
   irq_level_a: assert property (
      irq == (status && int_enable))
      else $error("interrupt level differs from enabled status");
   wake_pulse_a: assert property (
      ovf && sleep && int_enable |=> wake && status)
      else $error("overflow in sleep did not wake");
   sleep_bypass_count_a: assert property (
      sleep && ctrl.counter_on && ctrl.clock_source_select == timer_pkg::CS_EXT
      && ctrl.ext_clock_sync_bypass && !gate_cfg.gate_enable && ctrl.prescale_select == 2'h0
      && pre_cnt == 3'h0 && ext_async && !wr_count |=> count == $past(count) + 16'h0001)
      else $error("bypass external edge not counted in sleep");
   reserved_source_a: assert property (
      ctrl.clock_source_select == 2'h3 && !wr_count |=> $stable(count))
      else $error("reserved clock source counted");
   low_write_wins_a: assert property (
      wr_low |=> count[7:0] == $past(pwdata[7:0]))
      else $error("count low write lost to increment");
   aux_a_gate_a: assert property (
      ctrl.counter_on && gate_cfg.gate_source_select == timer_pkg::GSS_AUX_A
      |=> gate_ff == ($past(aux_a_overflow) == $past(gate_cfg.gate_polarity)))
      else $error("gate flop ignores aux A source");
   wdt_gate_a: assert property (
      ctrl.counter_on && gate_cfg.gate_source_select == timer_pkg::GSS_WDT
      |=> gate_ff == ($past(wdt_timeout) == $past(gate_cfg.gate_polarity)))
      else $error("gate flop ignores watchdog source");
   unmapped_error_a: assert property (
      access && !pready && !mapped |=> pready && pslverr)
      else $error("unmapped access not refused");

   overflow_c: cover property (ovf);
   gate_hold_c: cover property (gate_cfg.gate_enable && !gate_ff && active_tick);
   async_sleep_c: cover property (sleep && ext_async && ctrl.ext_clock_sync_bypass && count_en);
   wake_c: cover property (wake);
   sync_ext_c: cover property (ctrl.clock_source_select == timer_pkg::CS_EXT
      && !ctrl.ext_clock_sync_bypass && pre_tick);
endmodule : gated_sixteen_bit_timer

/* verif/ext_pin_model.sv */
// External clock pin source driving the timer's asynchronous clock input.
// Assumes run is driven on clk; the pin rests low while run is low.
module ext_pin_model #(
   parameter int HALF_PERIOD = 4
) (
   // Clock
   input wire logic clk,
   // Control
   input wire logic run,
   // Pin
   output logic ext_clock_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   int count = 0;

   initial ext_clock_pin = 1'b0;
   // Pin stands still outside a run, so no stray edge reaches the counter
   always @(posedge clk) begin
      if (!run) begin
         count <= 0;
         ext_clock_pin <= 1'b0;
      end else if (count == HALF_PERIOD - 1) begin
         count <= 0;
         ext_clock_pin <= ~ext_clock_pin;
      end else begin
         count <= count + 1;
      end
   end
endmodule : ext_pin_model

/* verif/gated_sixteen_bit_timer_tb.sv */
// Self-checking bench of the gated sixteen-bit timer over APB.
// Assumes the designer's one wait state APB slave and registered outputs.
module gated_sixteen_bit_timer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, ext_clock_pin, irq, wake;
   logic sleep = 1'b0, ext_run = 1'b0;
   logic gate_pin = 1'b0, aux_a_overflow = 1'b0, aux_b_match = 1'b0, wdt_timeout = 1'b0;
   int fails = 0;
   int samples_checked = 0;
   logic [31:0] rd;
   logic er;
   // Per case: control, gate control, pin running, asleep, expected count
   logic [7:0] cfg_ctrl [16] = '{8'h41, 8'h51, 8'h61, 8'h71, 8'h01, 8'hC1, 8'h81, 8'h85,
      8'h41, 8'h41, 8'h41, 8'h41, 8'h41, 8'h41, 8'h85, 8'h45};
   logic [7:0] cfg_gate [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h80, 8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'h00, 8'h00, 8'h00};
   logic cfg_ext [16] = '{0, 0, 0, 0, 0, 0, 1, 1, 0, 0, 0, 0, 0, 0, 1, 0};
   logic cfg_sleep [16] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 0};
   // Gate levels {watchdog, aux B, aux A, pin}: the selected source differs from the rest
   logic [3:0] cfg_gin [16] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
      4'hE, 4'hE, 4'h2, 4'hB, 4'h8, 4'h0, 4'h0, 4'h0};
   logic [15:0] cfg_exp [16] = '{16'h0080, 16'h0040, 16'h0020, 16'h0010, 16'h0020, 16'h0000,
      16'h0010, 16'h0010, 16'h0080, 16'h0000, 16'h0080, 16'h0000, 16'h0080, 16'h0000,
      16'h0010, 16'h0080};

   initial begin
      forever #5 clk = ~clk;
   end

   gated_sixteen_bit_timer DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_clock_pin(ext_clock_pin), .gate_pin(gate_pin),
      .aux_a_overflow(aux_a_overflow), .aux_b_match(aux_b_match), .wdt_timeout(wdt_timeout),
      .sleep(sleep),
      .irq(irq), .wake(wake));

   ext_pin_model pins (.clk(clk), .run(ext_run), .ext_clock_pin(ext_clock_pin));

   task automatic final_report();
      if (fails == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask : check_eq

   // Counts taken over a window known to a few cycles only
   task automatic check_near(input logic [15:0] got, input logic [15:0] exp);
      logic ok;
      ok = (got + 16'h0004 >= exp) && (got <= exp + 16'h0004);
      samples_checked++;
      if (ok !== 1'b1) begin
         fails++;
         $display("CHECK FAILED %0t count %h expected near %h", $time, got, exp);
      end
   endtask : check_near

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         fails++;
         final_report();
      end
   endtask : apb

   task automatic reg_scenario();
      apb(0, timer_pkg::ADDR_CONTROL, 32'h0000_0000);
      check_eq(rd, 32'h0000_0000);
      apb(1, timer_pkg::ADDR_CONTROL, 32'h0000_00FF);
      apb(0, timer_pkg::ADDR_CONTROL, 32'h0000_0000);
      check_eq(rd, 32'h0000_00F5);
      apb(1, timer_pkg::ADDR_CONTROL, 32'h0000_0000);
      apb(0, 8'h1C, 32'h0000_0000);
      check_eq({31'h0000_0000, er}, 32'h0000_0001);
      check_eq(rd, 32'h0000_0000);
   endtask : reg_scenario

   // Stopped count writes also clear the hidden prescaler before each case
   task automatic count_scenario();
      logic [15:0] cnt;
      for (int i = 0; i < 16; i++) begin
         apb(1, timer_pkg::ADDR_COUNT_LOW, 32'h0000_0000);
         apb(1, timer_pkg::ADDR_COUNT_HIGH, 32'h0000_0000);
         apb(1, timer_pkg::ADDR_GATE_CONTROL, {24'h00_0000, cfg_gate[i]});
         {wdt_timeout, aux_b_match, aux_a_overflow, gate_pin} <= cfg_gin[i];
         sleep <= cfg_sleep[i];
         ext_run <= cfg_ext[i];
         apb(1, timer_pkg::ADDR_CONTROL, {24'h00_0000, cfg_ctrl[i]});
         repeat (128) @(posedge clk);
         apb(1, timer_pkg::ADDR_CONTROL, 32'h0000_0000);
         ext_run <= 1'b0;
         sleep <= 1'b0;
         apb(0, timer_pkg::ADDR_COUNT_LOW, 32'h0000_0000);
         cnt[7:0] = rd[7:0];
         apb(0, timer_pkg::ADDR_COUNT_HIGH, 32'h0000_0000);
         cnt[15:8] = rd[7:0];
         check_near(cnt, cfg_exp[i]);
      end
   endtask : count_scenario

   task automatic overflow_scenario();
      logic seen;
      seen = 1'b0;
      apb(1, timer_pkg::ADDR_GATE_CONTROL, 32'h0000_0000);
      apb(1, timer_pkg::ADDR_COUNT_LOW, 32'h0000_00F8);
      apb(1, timer_pkg::ADDR_COUNT_HIGH, 32'h0000_00FF);
      apb(1, timer_pkg::ADDR_INT_ENABLE, 32'h0000_0001);
      sleep <= 1'b1;
      ext_run <= 1'b1;
      apb(1, timer_pkg::ADDR_CONTROL, 32'h0000_0085);
      for (int n = 0; n < 300 && !seen; n++) begin
         @(posedge clk);
         seen = (wake === 1'b1);
      end
      check_eq({31'h0000_0000, seen}, 32'h0000_0001);
      apb(1, timer_pkg::ADDR_CONTROL, 32'h0000_0000);
      ext_run <= 1'b0;
      sleep <= 1'b0;
      check_eq({31'h0000_0000, irq}, 32'h0000_0001);
      apb(1, timer_pkg::ADDR_INT_ENABLE, 32'h0000_0000);
      apb(0, timer_pkg::ADDR_INT_STATUS, 32'h0000_0000);
      check_eq(rd, 32'h0000_0001);
      check_eq({31'h0000_0000, irq}, 32'h0000_0000);
      apb(1, timer_pkg::ADDR_INT_CLEAR, 32'h0000_0001);
      apb(0, timer_pkg::ADDR_INT_STATUS, 32'h0000_0000);
      check_eq(rd, 32'h0000_0000);
   endtask : overflow_scenario

   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      reg_scenario();
      count_scenario();
      overflow_scenario();
      final_report();
   end
endmodule : gated_sixteen_bit_timer_tb
